// *** rtl/cppa_pkg.sv ***
package cppa_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int unsigned NCAB      = 5;
  localparam int unsigned CNT_W     = 3;
  localparam int unsigned CODE_W    = 3;
  localparam int unsigned CODES_W   = NCAB * CODE_W;
  localparam int unsigned ADR_W     = 4;
  localparam int unsigned DAT_W     = 32;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned MAP_IDX_W = 3;
  localparam int unsigned ST_W      = 2;
  localparam int unsigned FILT_W    = 3;

  // ********************************************************************
  // Register map, byte addresses
  // ********************************************************************
  localparam logic [ADR_W-1:0] ADR_CTRL   = 4'h0;
  localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] ADR_CODES  = 4'h8;

  localparam int unsigned CTRL_ALL150_BIT  = 0;
  localparam int unsigned CTRL_MAP_EN_BIT  = 1;
  localparam int unsigned CTRL_MAP_IDX_LSB = 4;

  localparam int unsigned STAT_LIVE_LSB    = 0;
  localparam int unsigned STAT_CNT_LSB     = 8;
  localparam int unsigned STAT_LAT_CNT_LSB = 12;
  localparam int unsigned STAT_STATE_LSB   = 16;
  localparam int unsigned STAT_RAILS_BIT   = 20;
  localparam int unsigned STAT_LAT_LSB     = 24;

  // ********************************************************************
  // Counts and filter
  // ********************************************************************
  localparam logic [CNT_W-1:0]  CNT_ONE       = 3'h1;
  localparam logic [CNT_W-1:0]  CNT_TWO       = 3'h2;
  localparam logic [CNT_W-1:0]  CNT_THREE     = 3'h3;
  localparam logic [CNT_W-1:0]  CNT_FOUR      = 3'h4;
  localparam logic [CNT_W-1:0]  CNT_FIVE      = 3'h5;
  localparam logic [CNT_W-1:0]  MAX_150_CARDS = 3'h4;
  localparam logic [FILT_W-1:0] FILT_LIMIT    = 3'h7;
  localparam logic [FILT_W-1:0] FILT_ONE      = 3'h1;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [ST_W-1:0] {
    ST_STANDBY = 2'b00,
    ST_RAMP    = 2'b01,
    ST_ON      = 2'b10
  } cppa_state_type;

  // Code bits: bit0 grounded, bit1 grounded, lines shorted
  localparam int unsigned CODE_B0    = 0;
  localparam int unsigned CODE_B1    = 1;
  localparam int unsigned CODE_SHORT = 2;

  typedef enum logic [CODE_W-1:0] {
    CODE_0W   = 3'b000,
    CODE_300W = 3'b001,
    CODE_450W = 3'b010,
    CODE_600W = 3'b011,
    CODE_150W = 3'b100
  } cppa_code_type;

  function automatic logic [CNT_W-1:0] cppa_count(input logic [NCAB-1:0] m);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < NCAB; i++) begin
      n = n + {{(CNT_W-1){1'b0}}, m[i]};
    end
    return n;
  endfunction

endpackage

// *** rtl/cppa_presence_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module cppa_presence_filter (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Presence lines
  input  wire logic [cppa_pkg::NCAB-1:0] line_n_i,
  input  wire logic [cppa_pkg::NCAB-1:0] hold_i,
  output logic      [cppa_pkg::NCAB-1:0] present_o
);
  import cppa_pkg::*;

  typedef struct packed {
    logic [NCAB-1:0]             present;
    logic [NCAB-1:0][FILT_W-1:0] cnt;
  } cppa_filt_state_type;

  cppa_filt_state_type q_r;
  cppa_filt_state_type q_nxt;

  // ********************************************************************
  // Polling, every line every cycle
  // ********************************************************************
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < NCAB; i++) begin
      // A driven line reads high; keep the last verdict meanwhile
      if (hold_i[i]) begin
        q_nxt.cnt[i] = '0;
      end else if (!line_n_i[i] == q_r.present[i]) begin // [RULE_01] [RULE_02] [RULE_03]
        q_nxt.cnt[i] = '0;
      end else if (q_r.cnt[i] == FILT_LIMIT) begin
        q_nxt.present[i] = !line_n_i[i];                 // [RULE_01]
        q_nxt.cnt[i]     = '0;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + FILT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign present_o = q_r.present;

endmodule // cppa_presence_filter
`default_nettype wire

// *** rtl/cppa_alloc_policy.sv ***
`timescale 1ns/1ns
`default_nettype none
module cppa_alloc_policy (
  // Detected cards and option
  input  wire logic [cppa_pkg::NCAB-1:0]    present_i,
  input  wire logic                         all_150_i,
  // Allocation
  output logic      [cppa_pkg::CNT_W-1:0]   count_o,
  output logic      [cppa_pkg::CODES_W-1:0] codes_o
);
  import cppa_pkg::*;

  // ********************************************************************
  // Share by card count, lowest cable index served first
  // ********************************************************************
  always_comb begin
    logic [CNT_W-1:0] granted;
    cppa_code_type    share;
    granted = '0;
    share   = CODE_0W;
    count_o = cppa_count(present_i);
    case (count_o)
      CNT_ONE:   share = CODE_600W;   // [RULE_06]
      CNT_TWO:   share = CODE_300W;   // [RULE_06]
      default:   share = CODE_150W;   // [RULE_06]
    endcase
    codes_o = '0;                     // [RULE_08]
    for (int i = 0; i < NCAB; i++) begin
      // Past four cards the rest get nothing unless overcommit is allowed
      if (present_i[i] && (all_150_i || granted < MAX_150_CARDS)) begin // [RULE_07] [RULE_09]
        codes_o[i*CODE_W +: CODE_W] = share;
        granted = granted + CNT_ONE;
      end
    end
  end

endmodule // cppa_alloc_policy
`default_nettype wire

// *** rtl/cppa_cable_power_alloc.sv ***
// Contract
// RULE_01: A high presence line means no cable; a low line means a card.
// RULE_02: Presence lines are polled separately, before and after main power.
// RULE_03: Cards pull their presence line low even while unpowered.
// RULE_04: Limit codes change only in standby: request off and rails off.
// RULE_05: With request on and rails up, every limit code output stays fixed.
// RULE_06: One card 600 W, two cards 300 W, three or four 150 W.
// RULE_07: With five cards, four get 150 W and one gets zero.
// RULE_08: Zero watts is legal and leaves both code lines open.
// RULE_09: Optionally all five cards get 150 W instead of disabling one.
// RULE_10: Mapping mode drives presence high push-pull only on confirmed cables.
// RULE_11: Mapping-capable cards latch the sensed level in their detect register.
// RULE_12: Mapping drives one cable high at a time, stepped in succession.
// RULE_13: Codes: 600 both grounded, 450 bit1 grounded, 300 bit0, 150 shorted.
// RULE_14: Count and codes latch at power up, recomputed only in standby.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module cppa_cable_power_alloc (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [cppa_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [cppa_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [cppa_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [cppa_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                              wb_ack_o,
  // Cable presence lines
  input  wire logic [cppa_pkg::NCAB-1:0]    cable_presence_n_i,
  output logic      [cppa_pkg::NCAB-1:0]    cable_presence_n_o,
  output logic      [cppa_pkg::NCAB-1:0]    cable_presence_n_oe_o,
  // Supply state
  input  wire logic                         supply_on_request_n_i,
  input  wire logic                         rails_ok_i,
  // Power limit code switches
  output logic      [cppa_pkg::NCAB-1:0]    power_limit_code_bit0_gnd_o,
  output logic      [cppa_pkg::NCAB-1:0]    power_limit_code_bit1_gnd_o,
  output logic      [cppa_pkg::NCAB-1:0]    power_limit_code_short_o
);
  import cppa_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    cppa_state_type         st;
    logic                   all_150;
    logic                   map_en;
    logic [MAP_IDX_W-1:0]   map_idx;
    logic [CNT_W-1:0]       lat_cnt;
    logic [NCAB-1:0]        lat_present;
    logic [CODES_W-1:0]     codes;
    logic [NCAB-1:0]        pres_oe;
    logic [NCAB-1:0]        pres_val;
    logic                   ack;
    logic [DAT_W-1:0]       dat;
  } cppa_top_state_type;

  cppa_top_state_type q_r;
  cppa_top_state_type q_nxt;

  logic [NCAB-1:0]    present_f;
  logic [CNT_W-1:0]   pol_count;
  logic [CODES_W-1:0] pol_codes;
  logic               live_w;
  logic               take_w;

  // ********************************************************************
  // Leaves
  // ********************************************************************
  cppa_presence_filter u_filter (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .line_n_i  (cable_presence_n_i),
    .hold_i    (q_r.pres_oe),
    .present_o (present_f)
  );

  cppa_alloc_policy u_policy (
    .present_i (present_f),
    .all_150_i (q_r.all_150),
    .count_o   (pol_count),
    .codes_o   (pol_codes)
  );

  // Standby proper: no request and no rails
  assign live_w = (q_r.st == ST_STANDBY) && supply_on_request_n_i && !rails_ok_i;
  assign take_w = wb_cyc_i && wb_stb_i && !q_r.ack;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    logic [DAT_W-1:0] rd;
    rd = '0;
    q_nxt = q_r;
    q_nxt.ack = 1'b0;

    // Register read mux; unmapped words read zero
    case (wb_adr_i)
      ADR_CTRL: begin
        rd[CTRL_ALL150_BIT]                   = q_r.all_150;
        rd[CTRL_MAP_EN_BIT]                   = q_r.map_en;
        rd[CTRL_MAP_IDX_LSB +: MAP_IDX_W]     = q_r.map_idx;
      end
      ADR_STATUS: begin
        rd[STAT_LIVE_LSB +: NCAB]             = present_f;
        rd[STAT_CNT_LSB +: CNT_W]             = pol_count;
        rd[STAT_LAT_CNT_LSB +: CNT_W]         = q_r.lat_cnt;
        rd[STAT_STATE_LSB +: ST_W]            = q_r.st;
        rd[STAT_RAILS_BIT]                    = rails_ok_i;
        rd[STAT_LAT_LSB +: NCAB]              = q_r.lat_present;
      end
      ADR_CODES: begin
        rd[CODES_W-1:0]                       = q_r.codes;
      end
      default: begin
        rd = '0;
      end
    endcase

    if (take_w) begin
      q_nxt.ack = 1'b1;
      q_nxt.dat = rd;
      if (wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
        q_nxt.all_150 = wb_dat_i[CTRL_ALL150_BIT];
        q_nxt.map_en  = wb_dat_i[CTRL_MAP_EN_BIT];
        q_nxt.map_idx = wb_dat_i[CTRL_MAP_IDX_LSB +: MAP_IDX_W];
      end
    end

    // Power sequencing
    case (q_r.st)
      ST_STANDBY: begin
        // Codes follow the cards only here; the last value is what powers up
        if (live_w) begin
          q_nxt.codes       = pol_codes;     // [RULE_04] [RULE_13]
          q_nxt.lat_cnt     = pol_count;     // [RULE_14]
          q_nxt.lat_present = present_f;     // [RULE_14]
        end
        if (!supply_on_request_n_i) begin
          q_nxt.st = ST_RAMP;                // [RULE_14]
        end
      end
      ST_RAMP: begin
        if (supply_on_request_n_i && !rails_ok_i) begin
          q_nxt.st = ST_STANDBY;
        end else if (rails_ok_i) begin
          q_nxt.st = ST_ON;                  // [RULE_05]
        end
      end
      ST_ON: begin
        // Rails must be gone too before codes may move again
        if (supply_on_request_n_i && !rails_ok_i) begin
          q_nxt.st = ST_STANDBY;             // [RULE_05] [RULE_14]
        end
      end
      default: begin
        q_nxt.st = ST_STANDBY;
      end
    endcase

    // Mapping drive: selected cable only, and only if a card is confirmed
    for (int i = 0; i < NCAB; i++) begin
      q_nxt.pres_oe[i] = q_r.map_en && (q_r.map_idx == MAP_IDX_W'(i))
                         && present_f[i];    // [RULE_10] [RULE_12] [RULE_11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r          <= '0;
      q_r.st       <= ST_STANDBY;
      q_r.pres_val <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ********************************************************************
  // Outputs, all from flops
  // ********************************************************************
  assign wb_ack_o              = q_r.ack;
  assign wb_dat_o              = q_r.dat;
  assign cable_presence_n_o    = q_r.pres_val;
  assign cable_presence_n_oe_o = q_r.pres_oe;

  for (genvar g = 0; g < NCAB; g++) begin : g_code
    assign power_limit_code_bit0_gnd_o[g] = q_r.codes[g*CODE_W + CODE_B0];    // [RULE_13]
    assign power_limit_code_bit1_gnd_o[g] = q_r.codes[g*CODE_W + CODE_B1];    // [RULE_13]
    assign power_limit_code_short_o[g]    = q_r.codes[g*CODE_W + CODE_SHORT]; // [RULE_13]
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  logic [CODES_W-1:0] code_pins_w;
  assign code_pins_w = {power_limit_code_short_o, power_limit_code_bit1_gnd_o,
                        power_limit_code_bit0_gnd_o};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_standby_live;
    live_w;
  endsequence

  sequence s_enter_on;
    s_standby_live ##1 (q_r.st == ST_STANDBY && !supply_on_request_n_i) ##1 (q_r.st == ST_RAMP);
  endsequence

  property p_latch_at_on;
    s_enter_on |-> (q_r.lat_cnt == $past(pol_count, 2));
  endproperty
  a_latch_at_on: // [RULE_14]
    assert property (p_latch_at_on) else $error("card count not latched at power up");

  property p_standby_only;
    !$stable(code_pins_w) |-> $past(live_w);
  endproperty
  a_standby_only: // [RULE_04]
    assert property (p_standby_only) else $error("limit code moved outside standby");

  property p_hold_on;
    (q_r.st == ST_ON && rails_ok_i) |=> $stable(code_pins_w) [*2];
  endproperty
  a_hold_on: // [RULE_05]
    assert property (p_hold_on) else $error("limit code moved with rails up");

  property p_absent_open;
    s_standby_live |=> ((power_limit_code_bit0_gnd_o | power_limit_code_bit1_gnd_o
                        | power_limit_code_short_o) & ~$past(present_f)) == '0;
  endproperty
  a_absent_open: // [RULE_01] [RULE_08]
    assert property (p_absent_open) else $error("absent cable given power");

  property p_one_card;
    (s_standby_live and (pol_count == CNT_ONE)) |=>
      ((power_limit_code_bit0_gnd_o & power_limit_code_bit1_gnd_o) == $past(present_f))
      && (power_limit_code_short_o == '0);
  endproperty
  a_one_card: // [RULE_06]
    assert property (p_one_card) else $error("single card not given 600 W");

  property p_two_cards;
    (s_standby_live and (pol_count == CNT_TWO)) |=>
      (power_limit_code_bit0_gnd_o == $past(present_f))
      && (power_limit_code_bit1_gnd_o == '0) && (power_limit_code_short_o == '0);
  endproperty
  a_two_cards: // [RULE_06]
    assert property (p_two_cards) else $error("two cards not given 300 W");

  property p_few_cards;
    (s_standby_live and (pol_count == CNT_THREE || pol_count == CNT_FOUR)) |=>
      (power_limit_code_short_o == $past(present_f))
      && ((power_limit_code_bit0_gnd_o | power_limit_code_bit1_gnd_o) == '0);
  endproperty
  a_few_cards: // [RULE_06]
    assert property (p_few_cards) else $error("three or four cards not given 150 W");

  property p_five_cut;
    (s_standby_live and (pol_count == CNT_FIVE) and !q_r.all_150) |=>
      ($countones(power_limit_code_short_o) == int'(MAX_150_CARDS))
      && ((power_limit_code_bit0_gnd_o | power_limit_code_bit1_gnd_o) == '0);
  endproperty
  a_five_cut: // [RULE_07]
    assert property (p_five_cut) else $error("five cards not cut to four");

  property p_five_all;
    (s_standby_live and (pol_count == CNT_FIVE) and q_r.all_150) |=>
      (power_limit_code_short_o == '1);
  endproperty
  a_five_all: // [RULE_09]
    assert property (p_five_all) else $error("overcommit did not enable all five");

  property p_map_one;
    $onehot0(cable_presence_n_oe_o);
  endproperty
  a_map_one: // [RULE_12]
    assert property (p_map_one) else $error("more than one cable driven");

  property p_map_confirmed;
    (cable_presence_n_oe_o != '0) |->
      ((cable_presence_n_oe_o & ~$past(present_f)) == '0) && $past(q_r.map_en)
      && (cable_presence_n_o == '1);
  endproperty
  a_map_confirmed: // [RULE_10]
    assert property (p_map_confirmed) else $error("unconfirmed cable driven");

  sequence s_not_standby;
    !supply_on_request_n_i || rails_ok_i;
  endsequence

  property p_freeze_inputs;
    s_not_standby |=> $stable(code_pins_w);
  endproperty
  a_freeze_inputs: // [RULE_04]
    assert property (p_freeze_inputs) else $error("limit code moved with request or rails on");

  sequence s_rails_up;
    (q_r.st == ST_ON) && rails_ok_i;
  endsequence

  property p_stay_on;
    s_rails_up |=> (q_r.st == ST_ON);
  endproperty
  a_stay_on: // [RULE_05]
    assert property (p_stay_on) else $error("left power on with rails up");

  property p_latch_frozen;
    (q_r.st != ST_STANDBY) |=> $stable(q_r.lat_present) && $stable(q_r.lat_cnt);
  endproperty
  a_latch_frozen: // [RULE_14]
    assert property (p_latch_frozen) else $error("latched cards moved outside standby");

  property p_latch_count;
    q_r.lat_cnt == CNT_W'($countones(q_r.lat_present));
  endproperty
  a_latch_count: // [RULE_14]
    assert property (p_latch_count) else $error("latched count disagrees with latched cards");

  // Grounding shorted lines would read as full power at the card
  property p_short_floats;
    (power_limit_code_short_o
     & (power_limit_code_bit0_gnd_o | power_limit_code_bit1_gnd_o)) == '0;
  endproperty
  a_short_floats: // [RULE_13]
    assert property (p_short_floats) else $error("shorted code lines also grounded");

  property p_map_off;
    !q_r.map_en |=> (cable_presence_n_oe_o == '0);
  endproperty
  a_map_off: // [RULE_10]
    assert property (p_map_off) else $error("cable driven with mapping off");

  property p_map_range;
    (q_r.map_idx >= MAP_IDX_W'(NCAB)) |=> (cable_presence_n_oe_o == '0);
  endproperty
  a_map_range: // [RULE_12]
    assert property (p_map_range) else $error("cable driven for an index past the last cable");

  property p_drive_high;
    cable_presence_n_o == '1;
  endproperty
  a_drive_high: // [RULE_10]
    assert property (p_drive_high) else $error("presence drive value not high");

endmodule // cppa_cable_power_alloc
`default_nettype wire

// *** test/cppa_card_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********************************************************************
// Add-in cards on the far end of the cables
// ********************************************************************
module cppa_card_model
  import cppa_pkg::*;
(
  // Clock
  input  wire logic            clk_i,
  // Cards attached and supply drive
  input  wire logic [NCAB-1:0] attached_i,
  input  wire logic [NCAB-1:0] drive_i,
  input  wire logic [NCAB-1:0] drive_oe_i,
  // Wire level and card registers
  output logic      [NCAB-1:0] line_n_o,
  output logic      [NCAB-1:0] sense_detect_o
);
  // Pull-down holds even with the card unpowered; weak pull-up otherwise
  always_comb begin
    for (int i = 0; i < NCAB; i++) begin
      line_n_o[i] = drive_oe_i[i] ? drive_i[i] : ~attached_i[i];
    end
  end
  // Only an attached card records the sensed level
  always_ff @(posedge clk_i) begin
    sense_detect_o <= line_n_o & attached_i;
  end
endmodule // cppa_card_model
`default_nettype wire

// *** test/tb_cppa_cable_power_alloc.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_cppa_cable_power_alloc;
  import cppa_pkg::*;
  logic clk_i, rst_i, cyc, we, req_n, rails, ack;
  logic [ADR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DAT_W-1:0] dat_w, dat_r, rd;
  logic [NCAB-1:0]  att, line_n, drv, oe, b0, b1, sh, sense;
  int               error_cnt, tests_run;
  // ********************************************************************
  // Design and cards
  // ********************************************************************
  cppa_cable_power_alloc DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .cable_presence_n_i(line_n), .cable_presence_n_o(drv),
    .cable_presence_n_oe_o(oe), .supply_on_request_n_i(req_n), .rails_ok_i(rails),
    .power_limit_code_bit0_gnd_o(b0), .power_limit_code_bit1_gnd_o(b1),
    .power_limit_code_short_o(sh));
  cppa_card_model cards (.clk_i(clk_i), .attached_i(att), .drive_i(drv), .drive_oe_i(oe),
    .line_n_o(line_n), .sense_detect_o(sense));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle; ack and read data taken at the rising edge that shows ack
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [SEL_W-1:0] s,
                    input logic [DAT_W-1:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_r;
    cyc <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [CODES_W-1:0] exp_codes(input logic [NCAB-1:0] m, input logic a);
    logic [CODES_W-1:0] c;
    int n, k;
    c = '0;
    n = 0;
    k = 0;
    for (int i = 0; i < NCAB; i++) n += m[i];
    for (int i = 0; i < NCAB; i++) begin
      if (m[i]) begin
        if (n == 1) c[3*i+:3] = 3'h3;
        else if (n == 2) c[3*i+:3] = 3'h1;
        else if (k < 4 || a) c[3*i+:3] = 3'h4;
        k++;
      end
    end
    return c;
  endfunction
  task automatic chk_pins(input logic [CODES_W-1:0] c);
    for (int i = 0; i < NCAB; i++) begin
      chk({29'h0, sh[i], b1[i], b0[i]}, {29'h0, c[3*i+:3]});
    end
  endtask
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_policy();
    logic [NCAB-1:0] m [7] = '{5'h00, 5'h08, 5'h12, 5'h0B, 5'h1E, 5'h1F, 5'h1F};
    for (int j = 0; j < 7; j++) begin
      wb(1'b1, ADR_CTRL, 4'hF, {31'h0, j == 6});
      att <= m[j];
      wait_cyc(12);
      wb(1'b0, ADR_CODES, 4'hF, 32'h0);
      chk(rd, {17'h0, exp_codes(m[j], j == 6)});
      chk_pins(exp_codes(m[j], j == 6));
      wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
      chk({27'h0, rd[4:0]}, {27'h0, m[j]});
    end
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
  endtask
  task automatic t_hold();
    att <= 5'h01;
    wait_cyc(12);
    req_n <= 1'b0;
    wait_cyc(2);
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk({30'h0, rd[17:16]}, 32'h1);
    rails <= 1'b1;
    att <= 5'h1F;
    wait_cyc(12);
    chk_pins(exp_codes(5'h01, 1'b0));
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk({29'h0, rd[10:8]}, 32'h5);
    chk({29'h0, rd[14:12]}, 32'h1);
    chk({30'h0, rd[17:16]}, 32'h2);
    req_n <= 1'b1;
    wait_cyc(4);
    chk_pins(exp_codes(5'h01, 1'b0));
    rails <= 1'b0;
    wait_cyc(4);
    chk_pins(exp_codes(5'h1F, 1'b0));
  endtask
  task automatic t_map();
    att <= 5'h15;
    wait_cyc(12);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ADR_CTRL, 4'hF, {25'h0, 3'(i), 4'h2});
      wait_cyc(3);
      chk({27'h0, oe}, (i < 5) ? {27'h0, att & 5'(1 << i)} : 32'h0);
      chk({27'h0, drv}, 32'h1F);
      chk({27'h0, sense}, {27'h0, att & 5'(1 << i)});
    end
    wb(1'b1, ADR_CTRL, 4'hF, 32'h22);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h20);
    wait_cyc(3);
    chk({27'h0, oe}, 32'h0);
  endtask
  task automatic t_bus();
    wb(1'b0, 4'hC, 4'hF, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ADR_CTRL, 4'h0, 32'h73);
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk(rd, 32'h20);
    wb(1'b1, ADR_CODES, 4'hF, 32'hFFFF);
    wb(1'b0, ADR_CODES, 4'hF, 32'h0);
    chk(rd, {17'h0, exp_codes(att, 1'b0)});
    wb(1'b1, ADR_CTRL, 4'hF, 32'h73);
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk(rd, 32'h73);
  endtask
  // ********************************************************************
  // Main sequence and watchdog
  // ********************************************************************
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {cyc, we, rails} = '0;
    req_n = 1'b1;
    adr = '0;
    sel = '0;
    dat_w = '0;
    att = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(1);
    chk({27'h0, drv}, 32'h1F);
    chk({27'h0, oe | b0 | b1 | sh}, 32'h0);
    t_policy();
    t_hold();
    t_map();
    t_bus();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
endmodule // tb_cppa_cable_power_alloc
`default_nettype wire
